// File: hdl/cmsr_pkg.sv
// Package for the comparator status and reference control block.
// Assumes an APB slave with 32-bit data and a single 20 MHz clock.
// Function
// - Comparator 1 output status, synchronized, zero when disabled
// - Comparator 0 output in bit 4, zero when disabled
// - Comparator 1 flag bit 1 set on selected edge
// - Comparator 1 interrupt only when its enable set
// - Comparator 0 flag bit 0 set on selected edge
// - Comparator 0 interrupt only when its enable set
// - Writing one clears flag; zero leaves it
// - Reference bit 9 drives bias enable
// - Reference bit 8 drives reference function enable
// - Reference bit 6 selects supply or bandgap source
// - Reference bits 3:0 drive ladder level code
// - Polarity 00 both, 01 rising, 10 falling
// - Control bit 0 enables comparator
// - Control bit 1 enables comparator interrupt
package cmsr_pkg;
  localparam logic [11:0] OFF_CTL0 = 12'h000;
  localparam logic [11:0] OFF_CTL1 = 12'h004;
  localparam logic [11:0] OFF_STATUS = 12'h008;
  localparam logic [11:0] OFF_REF = 12'h00c;
  localparam logic [11:0] OFF_IMASK = 12'h010;
  localparam int CTL_EN_BIT = 0;
  localparam int CTL_IE_BIT = 1;
  localparam int CTL_POL_LO = 20;
  localparam int STS_IF0_BIT = 0;
  localparam int STS_OUT0_BIT = 4;
  localparam int REF_LEVEL_LO = 0;
  localparam int REF_SRC_BIT = 6;
  localparam int REF_FN_BIT = 8;
  localparam int REF_BIAS_BIT = 9;
  localparam logic [31:0] CTL_WMASK = 32'h0030_0003;
  localparam logic [31:0] REF_WMASK = 32'h0000_034f;
  localparam logic [31:0] IMASK_WMASK = 32'h0000_0003;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [1:0] POL_BOTH = 2'h0;
  localparam logic [1:0] POL_RISE = 2'h1;
  localparam logic [1:0] POL_FALL = 2'h2;

  typedef struct packed {
    logic bias_enable;
    logic ref_function_enable;
    logic ref_source_select;
    logic [3:0] ref_level_code;
  } cmsr_ref_t;
endpackage : cmsr_pkg

// File: hdl/cmsr_top.sv
// Comparator status, edge flags, interrupt and reference control registers.
// Assumes raw comparator outputs are asynchronous; APB is zero-wait-state.
// Read data is registered at the end of setup and stands through access.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
module cmsr_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog side
  input wire logic [1:0] cmp_raw,
  output logic [1:0] cmp_enable,
  output cmsr_pkg::cmsr_ref_t comparator_reference_level,
  // Interrupts
  output logic [1:0] cmp_irq,
  output logic irq
);
  // Register state
  logic [31:0] ctl_r [2];
  logic [31:0] ctl_nxt [2];
  logic [31:0] ref_r;
  logic [31:0] ref_nxt;
  logic [1:0] imask_r;
  logic [1:0] imask_nxt;
  logic [1:0] flag_r;
  logic [1:0] flag_nxt;

  // Synchroniser and edge history
  logic [1:0] sync1_r;
  logic [1:0] sync1_nxt;
  logic [1:0] sync2_r;
  logic [1:0] sync2_nxt;
  logic [1:0] prev_r;
  logic [1:0] prev_nxt;

  // Registered outputs
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic [1:0] cmp_irq_r;
  logic [1:0] cmp_irq_nxt;
  logic irq_r;
  logic irq_nxt;

  // Bus decode and read path
  logic wr_en;
  logic setup_rd;
  logic [1:0] sel_ctl;
  logic sel_status;
  logic sel_ref;
  logic sel_imask;
  logic [1:0] wr_ctl;
  logic wr_status;
  logic wr_ref;
  logic wr_imask;
  logic mapped;
  logic [31:0] rd_nxt;
  logic [31:0] sts_word;
  logic [1:0] out_sts;

  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign setup_rd = psel && !penable && !pwrite;

  always_comb begin
    sel_ctl[0] = (paddr == cmsr_pkg::OFF_CTL0);
    sel_ctl[1] = (paddr == cmsr_pkg::OFF_CTL1);
    sel_status = (paddr == cmsr_pkg::OFF_STATUS);
    sel_ref = (paddr == cmsr_pkg::OFF_REF);
    sel_imask = (paddr == cmsr_pkg::OFF_IMASK);
  end

  // Writes act only at the edge that ends the access cycle
  always_comb begin
    wr_ctl = sel_ctl & {2{wr_en}};
    wr_status = sel_status && wr_en;
    wr_ref = sel_ref && wr_en;
    wr_imask = sel_imask && wr_en;
  end

  // Only the second stage is read; the first may still be settling
  always_comb begin
    sync1_nxt = cmp_raw;
    sync2_nxt = sync1_r;
    prev_nxt = out_sts;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1_r <= cmsr_pkg::REG_RESET[1:0];
    end else begin
      sync1_r <= sync1_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync2_r <= cmsr_pkg::REG_RESET[1:0];
    end else begin
      sync2_r <= sync2_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prev_r <= cmsr_pkg::REG_RESET[1:0];
    end else begin
      prev_r <= prev_nxt;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_cmp
      logic [1:0] pol;
      logic hit;
      logic clr;
      logic flag_next;
      logic [31:0] ctl_next;
      assign cmp_enable[i] = ctl_r[i][cmsr_pkg::CTL_EN_BIT];
      // Gating with enable blocks stale levels after disable
      assign out_sts[i] = sync2_r[i] & cmp_enable[i];
      assign pol = ctl_r[i][cmsr_pkg::CTL_POL_LO +: 2];
      always_comb begin
        unique case (pol)
          cmsr_pkg::POL_BOTH: begin
            hit = out_sts[i] ^ prev_r[i];
          end
          cmsr_pkg::POL_RISE: begin
            hit = out_sts[i] & ~prev_r[i];
          end
          cmsr_pkg::POL_FALL: begin
            hit = ~out_sts[i] & prev_r[i];
          end
          // Reserved code never raises a flag
          default: begin
            hit = 1'b0;
          end
        endcase
      end
      assign clr = wr_status & pwdata[cmsr_pkg::STS_IF0_BIT + i];
      // Set wins over a same-cycle clear so no edge is lost
      always_comb begin
        flag_next = flag_r[i];
        if (clr) begin
          flag_next = 1'b0;
        end
        if (hit) begin
          flag_next = 1'b1;
        end
      end
      // Reserved control bits are never stored
      always_comb begin
        ctl_next = ctl_r[i];
        if (wr_ctl[i]) begin
          ctl_next = pwdata & cmsr_pkg::CTL_WMASK;
        end
      end
      assign flag_nxt[i] = flag_next;
      assign ctl_nxt[i] = ctl_next;
      // Built from next state so the registered request has no extra delay
      assign cmp_irq_nxt[i] = flag_next & ctl_next[cmsr_pkg::CTL_IE_BIT];
    end
  endgenerate

  // Control words hold enable, interrupt enable and polarity only
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctl_r[0] <= cmsr_pkg::REG_RESET;
      ctl_r[1] <= cmsr_pkg::REG_RESET;
    end else begin
      ctl_r[0] <= ctl_nxt[0];
      ctl_r[1] <= ctl_nxt[1];
    end
  end

  always_comb begin
    ref_nxt = ref_r;
    if (wr_ref) begin
      ref_nxt = pwdata & cmsr_pkg::REF_WMASK;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ref_r <= cmsr_pkg::REG_RESET;
    end else begin
      ref_r <= ref_nxt;
    end
  end

  // Mask is this block's own gate on the shared interrupt line
  always_comb begin
    imask_nxt = imask_r;
    if (wr_imask) begin
      imask_nxt = pwdata[1:0] & cmsr_pkg::IMASK_WMASK[1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      imask_r <= cmsr_pkg::REG_RESET[1:0];
    end else begin
      imask_r <= imask_nxt;
    end
  end

  // Flags survive until software writes a one
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flag_r <= cmsr_pkg::REG_RESET[1:0];
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // Mask gates only the shared line, not the per-comparator requests
  always_comb begin
    irq_nxt = |(cmp_irq_nxt & imask_nxt);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cmp_irq_r <= cmsr_pkg::REG_RESET[1:0];
      irq_r <= cmsr_pkg::REG_RESET[0];
    end else begin
      cmp_irq_r <= cmp_irq_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign cmp_irq = cmp_irq_r;
  assign irq = irq_r;

  always_comb begin
    // Reserved status bits stay zero
    sts_word = cmsr_pkg::REG_RESET;
    sts_word[cmsr_pkg::STS_IF0_BIT +: 2] = flag_r;
    sts_word[cmsr_pkg::STS_OUT0_BIT +: 2] = out_sts;
  end

  always_comb begin
    mapped = 1'b1;
    rd_nxt = 32'h0000_0000;
    unique case (paddr)
      cmsr_pkg::OFF_CTL0: begin
        rd_nxt = ctl_r[0];
      end
      cmsr_pkg::OFF_CTL1: begin
        rd_nxt = ctl_r[1];
      end
      cmsr_pkg::OFF_STATUS: begin
        rd_nxt = sts_word;
      end
      cmsr_pkg::OFF_REF: begin
        rd_nxt = ref_r;
      end
      cmsr_pkg::OFF_IMASK: begin
        rd_nxt = {30'h0, imask_r};
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // Captured at the end of setup and held, so it stands through access
  always_comb begin
    prdata_nxt = prdata_r;
    if (setup_rd) begin
      prdata_nxt = rd_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdata_r <= cmsr_pkg::REG_RESET;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata = prdata_r;
  // Unmapped offsets answer with an error, never with a wait
  assign pslverr = psel && penable && !mapped;

  always_comb begin
    comparator_reference_level.bias_enable = ref_r[cmsr_pkg::REF_BIAS_BIT];
    comparator_reference_level.ref_function_enable = ref_r[cmsr_pkg::REF_FN_BIT];
    comparator_reference_level.ref_source_select = ref_r[cmsr_pkg::REF_SRC_BIT];
    comparator_reference_level.ref_level_code = ref_r[cmsr_pkg::REF_LEVEL_LO +: 4];
  end
endmodule : cmsr_top

// File: verification/cmsr_assertions.sv
// Port checker for cmsr_top.
// Bound below; APB reads settle in the access cycle.
`timescale 1ns/1ps
module cmsr_assertions (
  // Clock, reset, APB
  input wire logic core_clk, rst, psel, penable, pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  // Analog side, interrupts
  input wire logic irq,
  input wire logic [1:0] cmp_enable, cmp_irq,
  input wire cmsr_pkg::cmsr_ref_t comparator_reference_level);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire rs = psel && penable && !pwrite && paddr == 12'h008;
  wire c0_wr = psel && penable && pwrite && paddr == 12'h000;
  wire ref_wr = psel && penable && pwrite && paddr == 12'h00c;
  wire [6:0] lv = comparator_reference_level;
  a_out0_off: assert property (rs && !cmp_enable[0] |-> !prdata[4]) else $error("o0");
  a_out1_off: assert property (rs && !cmp_enable[1] |-> !prdata[5]) else $error("o1");
  a_irq0_flag: assert property (rs && !prdata[0] |-> !$past(cmp_irq[0])) else $error("i0");
  a_irq1_flag: assert property (rs && !prdata[1] |-> !$past(cmp_irq[1])) else $error("i1");
  a_fn_ref: assert property (ref_wr |=> lv[5] == $past(pwdata[8])) else $error("fn");
  a_en_ctl: assert property (c0_wr |=> cmp_enable[0] == $past(pwdata[0])) else $error("en");
  a_bias_ref: assert property (ref_wr |=> lv[6] == $past(pwdata[9])) else $error("bias");
  a_src_ref: assert property (ref_wr |=> lv[4] == $past(pwdata[6])) else $error("src");
  a_level_ref: assert property (ref_wr |=> lv[3:0] == $past(pwdata[3:0])) else $error("lv");
  c_irq: cover property (irq);
  c_flag1: cover property ($rose(cmp_irq[1]));
  c_ref: cover property (ref_wr);
endmodule : cmsr_assertions
bind cmsr_top cmsr_assertions i_cmsr_assertions (.*);

// File: verification/cmsr_raw_model.sv
// Model of the two comparator cores.
// Levels change at a rising edge, one cycle after they are requested.
`timescale 1ns/1ps
module cmsr_raw_model (
  input wire logic core_clk,
  input wire logic [1:0] raw_req,
  output logic [1:0] cmp_raw = 2'h0);
  always @(posedge core_clk) cmp_raw <= raw_req;
endmodule : cmsr_raw_model

// File: verification/tb_cmsr_top.sv
// Bench: reference and edge flag scenarios over APB.
// Assumes the core model settles within one clock.
`timescale 1ns/1ps
module tb_cmsr_top;
  logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic qe;
  logic [1:0] raw_req = 2'h0, cmp_raw, cmp_enable, cmp_irq;
  cmsr_pkg::cmsr_ref_t comparator_reference_level;
  int err_count = 0, tests_run = 0, cyc = 0;
  cmsr_top i_cmsr_top (.*);
  cmsr_raw_model i_cmsr_raw_model (.*);
  initial forever #25 core_clk = ~core_clk;
  always @(posedge core_clk) if (++cyc == 3000) begin
    err_count++;
    conclude();
  end
  task conclude;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    qe = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task t_ref;
    apb(1, 12'h00c, 32'hffff_ffff);
    apb(0, 12'h00c, 0);
    chk("ref", q, 32'h0000_034f);
    chk("okay", qe, 0);
    chk("lvl", comparator_reference_level, 32'h0000_007f);
    apb(1, 12'h00c, 32'h0000_0245);
    apb(0, 12'h014, 0);
    chk("gap", q, 0);
    chk("err", qe, 1);
    chk("lvl", comparator_reference_level, 32'h0000_0055);
  endtask : t_ref
  task t_edge;
    for (int i = 0; i < 2; i++) begin
      for (int p = 0; p < 4; p++) begin
        apb(1, 12'(4 * i), 32'h0000_0003 | 32'(p << 20));
        raw_req[i] <= 1'b1;
        apb(1, 12'h008, 0);
        apb(0, 12'h008, 0);
        chk("out", q[4 + i], 1);
        chk("rise", q[i], p < 2);
        chk("irq", irq, p < 2);
        chk("cirq", cmp_irq[i], p < 2);
        chk("en", cmp_enable[i], 1);
        apb(1, 12'h008, 32'(1 << i));
        raw_req[i] <= 1'b0;
        repeat (3) @(posedge core_clk);
        apb(0, 12'h008, 0);
        chk("fall", q[i], p == 0 || p == 2);
        apb(1, 12'h008, 32'h0000_0003);
      end
      raw_req[i] <= 1'b1;
      apb(1, 12'(4 * i), 0);
      apb(0, 12'h008, 0);
      chk("off", q[4 + i], 0);
      chk("dis", cmp_enable[i], 0);
      raw_req[i] <= 1'b0;
    end
  endtask : t_edge
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    apb(1, 12'h010, 32'h0000_0003);
    t_ref();
    t_edge();
    conclude();
  end
endmodule : tb_cmsr_top
